// *** hw/clkrst_map.svh ***
/*
 * Offsets, field positions, reset values and timing counts shared by both ends
 * of the clock, reset and status link.
 * Assumes a single 50 MHz aclk drives every end of the link.
 */
`ifndef CLKRST_MAP_SVH
`define CLKRST_MAP_SVH

// ============================================================
// Timing
`define CLK_HZ 50000000
`define QUIESCE_HOLD_MS 50
// Low time must exceed the completion timeout, so one cycle is added.
`define QUIESCE_HOLD_CYC (((`CLK_HZ / 1000) * `QUIESCE_HOLD_MS) + 1)
`define HOLD_CNT_W 22
`define STRETCH_W 5
`define FABRIC_STRETCH 5'h10
`define STRAP_DELAY 2'h3

// ============================================================
// Controller register map (byte offsets in a 4-bit address space)
`define ADDR_W 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define CTRL_SOFT_REQ 0
`define STAT_LINK_UP 0
`define STAT_MSI_EN 1
`define STAT_MSIX_EN 2
`define STAT_VEC_LSB 3
`define STAT_FABRIC_RSTN 6
`define STAT_SOFT_DONE 7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** hw/clkrst_pkg.sv ***
/*
 * Types shared by the device end, the user end and the link interface.
 * Assumes clkrst_map.svh is on the include path.
 */
`include "clkrst_map.svh"

package clkrst_pkg;

    // ============================================================
    // Common types
    typedef logic [2:0] vec_width_t;

    // Gray coded along idle, quiet, hold, wait.
    typedef enum logic [1:0] {
        FSM_IDLE  = 2'b00,
        FSM_QUIET = 2'b01,
        FSM_HOLD  = 2'b11,
        FSM_WAIT  = 2'b10
    } soft_fsm_t;

    // ============================================================
    // Device end state
    typedef struct packed {
        logic [1:0] boot;
        logic half_rate;
        logic sys_tick;
        logic fabric_clk;
        logic fabric_resetn;
        logic engine_resetn;
        logic [`STRETCH_W-1:0] stretch;
        logic link_up;
        logic msi_en;
        logic msix_en;
        vec_width_t msi_vecs;
    } dev_state_t;

    // ============================================================
    // User end state
    typedef struct packed {
        soft_fsm_t fsm;
        logic [`HOLD_CNT_W-1:0] cnt;
        logic soft_done;
        logic soft_resetn;
        logic pcie_rstn;
        logic fabric_aresetn;
        logic awready;
        logic aw_full;
        logic [`ADDR_W-1:0] aw_addr;
        logic wready;
        logic w_full;
        logic [7:0] w_data;
        logic w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } usr_state_t;

endpackage

// *** hw/clkrst_if.sv ***
/*
 * Link between the device end and the user end: resets in, fabric clock,
 * fabric reset and status out.
 * Assumes both ends run on the same aclk; no signal here crosses a domain.
 */
`timescale 1ns/1ps

interface clkrst_if;
    import clkrst_pkg::*;

    // ============================================================
    // Signals
    logic sys_rst_n;
    logic soft_resetn;
    logic fabric_clk;
    logic fabric_resetn;
    logic link_up;
    logic msi_enable;
    logic msix_enable;
    vec_width_t msi_vector_width;

    modport dev_mp (
        input sys_rst_n,
        input soft_resetn,
        output fabric_clk,
        output fabric_resetn,
        output link_up,
        output msi_enable,
        output msix_enable,
        output msi_vector_width
    );

    modport usr_mp (
        output sys_rst_n,
        output soft_resetn,
        input fabric_clk,
        input fabric_resetn,
        input link_up,
        input msi_enable,
        input msix_enable,
        input msi_vector_width
    );
endinterface

// *** hw/sync2.sv ***
/*
 * Two flip-flop level synchroniser of configurable width.
 * Assumes each bit is a slow level; multi-bit words may tear for one cycle.
 */
`timescale 1ns/1ps

module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } sync_state_t;

    sync_state_t q_r;
    sync_state_t q_nxt;

    // ============================================================
    // The first stage feeds only the second stage.
    always_comb begin
        q_nxt.s1 = async_in;
        q_nxt.s2 = q_r.s1;
    end

    // ============================================================
    // State register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sync_out = q_r.s2;
endmodule

// *** hw/dma_global_clock_reset_status.sv ***
/*
 * Device end of the clock, reset and status link: derives the internal
 * system tick and the fabric clock, sequences the fabric reset from the
 * edge-connector reset and the optional soft engine reset, and reports link
 * and interrupt configuration.
 * Assumes aclk stands for the transceiver transmit clock, that core status
 * levels come from another domain, and that the link partner shares aclk.
 */
`timescale 1ns/1ps
`include "clkrst_map.svh"

// Behaviour
// - system tick halves a 250 MHz reference
// - fabric reset changes synchronous to fabric clock
// - user wires fabric reset to interconnects
// - soft reset honoured only when enabled
// - no soft reset needed at first link-up
// - user quiesces traffic before soft reset
// - soft reset held beyond completion timeout
// - soft reset clears engines, keeps link up
// - link-up output follows core link state
// - MSI-enabled output follows host setting
// - MSI-X-enabled output follows host setting
// - three-bit allocated MSI vector count
// - system reset driven from edge connector
module dma_global_clock_reset_status #(
    parameter bit SOFT_RESET_EN = 1'b1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Strap: reference clock is 250 MHz
    input wire logic ref_is_250,
    // Core status from the link layer
    input wire logic core_link_up,
    input wire logic core_msi_enable,
    input wire logic core_msix_enable,
    input wire clkrst_pkg::vec_width_t core_msi_vecs,
    // Internal clocking and engine reset
    output logic sys_clk_tick,
    output logic engine_resetn,
    // Link to the user end
    clkrst_if.dev_mp lnk
);
    import clkrst_pkg::*;

    // ============================================================
    // Declarations
    dev_state_t q_r;
    dev_state_t q_nxt;
    logic [6:0] core_sync;
    logic hold_rst;
    logic fabric_fall;

    // ============================================================
    // Synchroniser for the core status levels and the strap.
    sync2 #(
        .W(7)
    ) u_core_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({ref_is_250, core_msi_vecs, core_msix_enable,
                   core_msi_enable, core_link_up}),
        .sync_out(core_sync)
    );

    // ============================================================
    // Reset causes. The soft input is ignored entirely when the build
    // option is off, so a floating tie-off cannot disturb the engines.
    always_comb begin
        hold_rst = !lnk.sys_rst_n;
        if (SOFT_RESET_EN && !lnk.soft_resetn) begin
            hold_rst = 1'b1;
        end
    end

    // The fabric clock is high now and falls at this edge.
    assign fabric_fall = q_r.fabric_clk;

    // ============================================================
    // Next-state logic for the whole device end.
    always_comb begin
        q_nxt = q_r;

        // The strap is sampled only after the synchroniser has flushed
        // its reset value, so the captured rate is the board's.
        if (q_r.boot != `STRAP_DELAY) begin
            q_nxt.boot = q_r.boot + 2'h1;
        end
        if (q_r.boot == (`STRAP_DELAY - 2'h1)) begin
            q_nxt.half_rate = core_sync[6];
        end

        // Internal system tick: toggling gives half rate, steady high gives
        // every edge, i.e. the full reference rate.
        if (q_r.half_rate) begin
            q_nxt.sys_tick = ~q_r.sys_tick;
        end else begin
            q_nxt.sys_tick = 1'b1;
        end

        // Fabric clock is a divide-by-two of the transmit clock. It keeps
        // running through reset so the release edge is always available.
        q_nxt.fabric_clk = ~q_r.fabric_clk;

        // Engines drop at once on any reset cause.
        q_nxt.engine_resetn = !hold_rst;

        // Fabric reset only changes when the fabric clock falls, so both
        // edges are stable around the user's rising fabric edge. Release is
        // stretched so interconnects see several clocks in reset.
        if (fabric_fall) begin
            if (hold_rst) begin
                q_nxt.fabric_resetn = 1'b0;
                q_nxt.stretch = `FABRIC_STRETCH;
            end else if (q_r.stretch != '0) begin
                q_nxt.stretch = q_r.stretch - `STRETCH_W'(1);
            end else begin
                q_nxt.fabric_resetn = 1'b1;
            end
        end

        // Link state survives a soft reset; only the system reset drops it.
        q_nxt.link_up = lnk.sys_rst_n & core_sync[0];
        q_nxt.msi_en = lnk.sys_rst_n & core_sync[1];
        q_nxt.msix_en = lnk.sys_rst_n & core_sync[2];
        if (lnk.sys_rst_n) begin
            q_nxt.msi_vecs = core_sync[5:3];
        end else begin
            q_nxt.msi_vecs = '0;
        end
    end

    // ============================================================
    // State register. Fabric reset comes up asserted with a full stretch.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= '{boot: 2'h0, half_rate: 1'b0, sys_tick: 1'b0,
                     fabric_clk: 1'b0, fabric_resetn: 1'b0,
                     engine_resetn: 1'b0, stretch: `FABRIC_STRETCH,
                     link_up: 1'b0, msi_en: 1'b0, msix_en: 1'b0,
                     msi_vecs: 3'h0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // ============================================================
    // Outputs, all straight from the state register.
    assign sys_clk_tick = q_r.sys_tick;
    assign engine_resetn = q_r.engine_resetn;
    assign lnk.fabric_clk = q_r.fabric_clk;
    assign lnk.fabric_resetn = q_r.fabric_resetn;
    assign lnk.link_up = q_r.link_up;
    assign lnk.msi_enable = q_r.msi_en;
    assign lnk.msix_enable = q_r.msix_en;
    assign lnk.msi_vector_width = q_r.msi_vecs;
endmodule

// *** hw/user_fabric_end.sv ***
/*
 * User end of the clock, reset and status link: passes the edge-connector
 * reset on, runs the soft engine reset sequence on software request and
 * exposes control and status over an AXI4-Lite slave.
 * Assumes perst_n is an asynchronous pin and traffic_idle is on aclk.
 */
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "clkrst_map.svh"

module user_fabric_end #(
    parameter int unsigned HOLD_CYCLES = `QUIESCE_HOLD_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Board and fabric levels
    input wire logic perst_n,
    input wire logic traffic_idle,
    output logic fabric_aresetn,
    // AXI4-Lite write channels
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Link to the device end
    clkrst_if.usr_mp lnk
);
    import clkrst_pkg::*;

    localparam logic [`HOLD_CNT_W-1:0] HOLD_LAST = `HOLD_CNT_W'(HOLD_CYCLES - 1);

    usr_state_t q_r;
    usr_state_t q_nxt;
    logic perst_sync;
    logic do_wr;

    // ============================================================
    // Address decode, shared by the read and write paths.
    function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
        return (a == `REG_CTRL) || (a == `REG_STATUS);
    endfunction

    function automatic logic [31:0] read_word(input logic [`ADDR_W-1:0] a,
                                              input usr_state_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == `REG_CTRL) begin
            v[`CTRL_SOFT_REQ] = (s.fsm != FSM_IDLE);
        end else if (a == `REG_STATUS) begin
            v[`STAT_LINK_UP] = lnk.link_up;
            v[`STAT_MSI_EN] = lnk.msi_enable;
            v[`STAT_MSIX_EN] = lnk.msix_enable;
            v[`STAT_VEC_LSB +: 3] = lnk.msi_vector_width;
            v[`STAT_FABRIC_RSTN] = lnk.fabric_resetn;
            v[`STAT_SOFT_DONE] = s.soft_done;
        end
        return v;
    endfunction

    // ============================================================
    // The edge-connector pin is synchronised before use.
    sync2 #(
        .W(1)
    ) u_perst_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(perst_n),
        .sync_out(perst_sync)
    );

    assign do_wr = q_r.aw_full && q_r.w_full && !q_r.bvalid;

    // ============================================================
    // Next-state logic: bus slave, then the soft reset sequence.
    always_comb begin
        q_nxt = q_r;
        q_nxt.pcie_rstn = perst_sync;
        q_nxt.fabric_aresetn = lnk.fabric_resetn;

        // Address and data are taken in either order, then joined.
        if (awvalid && q_r.awready) begin
            q_nxt.aw_full = 1'b1;
            q_nxt.aw_addr = awaddr;
        end
        if (wvalid && q_r.wready) begin
            q_nxt.w_full = 1'b1;
            q_nxt.w_data = wdata[7:0];
            q_nxt.w_strb = wstrb[0];
        end
        if (q_r.bvalid && bready) begin
            q_nxt.bvalid = 1'b0;
        end
        if (do_wr) begin
            q_nxt.aw_full = 1'b0;
            q_nxt.w_full = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp = is_mapped(q_r.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            if (q_r.w_strb && q_r.aw_addr == `REG_STATUS
                    && q_r.w_data[`STAT_SOFT_DONE]) begin
                q_nxt.soft_done = 1'b0;
            end
        end
        q_nxt.awready = !q_nxt.aw_full;
        q_nxt.wready = !q_nxt.w_full;

        // One read at a time; a new address is refused until rready.
        if (q_r.rvalid && rready) begin
            q_nxt.rvalid = 1'b0;
        end
        if (arvalid && q_r.arready) begin
            q_nxt.rvalid = 1'b1;
            q_nxt.rdata = read_word(araddr, q_r);
            q_nxt.rresp = is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        q_nxt.arready = !q_nxt.rvalid;

        // Soft reset runs only on request, never by itself at link-up.
        case (q_r.fsm)
            FSM_IDLE: begin
                if (do_wr && q_r.w_strb && q_r.aw_addr == `REG_CTRL
                        && q_r.w_data[`CTRL_SOFT_REQ]) begin
                    q_nxt.fsm = FSM_QUIET;
                end
            end
            FSM_QUIET: begin
                if (traffic_idle) begin
                    q_nxt.fsm = FSM_HOLD;
                    q_nxt.soft_resetn = 1'b0;
                    q_nxt.cnt = '0;
                end
            end
            FSM_HOLD: begin
                q_nxt.cnt = q_r.cnt + `HOLD_CNT_W'(1);
                if (q_r.cnt == HOLD_LAST) begin
                    q_nxt.fsm = FSM_WAIT;
                    q_nxt.soft_resetn = 1'b1;
                end
            end
            FSM_WAIT: begin
                if (lnk.fabric_resetn) begin
                    q_nxt.fsm = FSM_IDLE;
                    q_nxt.soft_done = 1'b1; // Set beats a same-cycle clear.
                end
            end
            default: begin
                q_nxt.fsm = FSM_IDLE;
                q_nxt.soft_resetn = 1'b1;
            end
        endcase
    end

    // ============================================================
    // State register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= '0;
            q_r.soft_resetn <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ============================================================
    // Outputs, all straight from the state register.
    assign fabric_aresetn = q_r.fabric_aresetn;
    assign awready = q_r.awready;
    assign wready = q_r.wready;
    assign bvalid = q_r.bvalid;
    assign bresp = q_r.bresp;
    assign arready = q_r.arready;
    assign rvalid = q_r.rvalid;
    assign rdata = q_r.rdata;
    assign rresp = q_r.rresp;
    assign lnk.sys_rst_n = q_r.pcie_rstn;
    assign lnk.soft_resetn = q_r.soft_resetn;
endmodule

// *** sim/clkrst_sva.sv ***
/*
 * Concurrent checks on the link between the device end and the user end.
 * Assumes one aclk for both ends and the soft engine reset enabled.
 */
`timescale 1ns/1ps

module clkrst_sva #(
    parameter int unsigned HOLD_CYCLES = 20
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link signals
    input wire logic sys_rst_n,
    input wire logic soft_resetn,
    input wire logic fabric_clk,
    input wire logic fabric_resetn,
    input wire logic link_up,
    input wire logic msi_enable,
    input wire logic msix_enable,
    input wire clkrst_pkg::vec_width_t msi_vector_width
);
    import clkrst_pkg::*;

    // ============================================================
    // Helper counters
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] quiet_r;
    logic [31:0] low_r;

    // Cycles since both reset causes left; saturates so a long run never wraps.
    always_ff @(posedge aclk) begin
        if (!aresetn || !sys_rst_n || !soft_resetn) begin
            quiet_r <= 8'h00;
        end else if (quiet_r != 8'hFF) begin
            quiet_r <= quiet_r + 8'h01;
        end
    end

    // Length of the current soft reset pulse.
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_resetn) begin
            low_r <= 32'h0;
        end else begin
            low_r <= low_r + 32'h1;
        end
    end

    // ============================================================
    // Assertions
    a_fabric_clk_runs: assert property ($past(aresetn) |-> fabric_clk != $past(fabric_clk))
        else $error("fabric clock stopped toggling");
    a_release_on_fall: assert property ($rose(fabric_resetn) |-> $past(fabric_clk) && !fabric_clk)
        else $error("fabric reset released off the fabric clock fall");
    a_sys_holds_fabric: assert property (!sys_rst_n [*4] |-> !fabric_resetn)
        else $error("fabric reset free during system reset");
    a_soft_holds_fabric: assert property (!soft_resetn [*4] |-> !fabric_resetn)
        else $error("fabric reset free during soft reset");
    a_release_stretch: assert property ($rose(fabric_resetn) |-> quiet_r inside {[8'd30:8'd38]})
        else $error("fabric reset released at the wrong time");
    a_release_bound: assert property (quiet_r == 8'd45 |-> fabric_resetn)
        else $error("fabric reset never released");
    a_soft_keeps_link: assert property (!soft_resetn && sys_rst_n && $past(link_up) |-> link_up)
        else $error("link dropped during soft reset");
    a_sys_clears_status: assert property (!sys_rst_n [*5] |-> !link_up && !msi_enable
        && !msix_enable && msi_vector_width == 3'h0)
        else $error("status set during system reset");
    a_soft_low_length: assert property ($rose(soft_resetn) |-> low_r == HOLD_CYCLES)
        else $error("soft reset pulse has the wrong length");

    c_fabric_release: cover property ($rose(fabric_resetn));
    c_soft_pulse: cover property ($rose(soft_resetn));
    c_link_up: cover property ($rose(link_up));
endmodule

// *** sim/tb_top.sv ***
/*
 * Testbench joining the device end and the user end over the link interface.
 * Assumes one 50 MHz aclk and a short soft reset hold for simulation.
 */
`timescale 1ns/1ps
`include "clkrst_map.svh"

module tb_top;
    import clkrst_pkg::*;

    // ============================================================
    // Signals
    localparam int HOLD = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic perst_n = 1'b0;
    logic traffic_idle = 1'b0;
    logic ref_is_250 = 1'b0;
    logic core_link_up = 1'b0;
    logic core_msi_enable = 1'b0;
    logic core_msix_enable = 1'b0;
    vec_width_t core_msi_vecs = 3'h0;
    logic sys_clk_tick, engine_resetn, fabric_aresetn;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_mismatch = 0;
    int comparisons = 0;

    // Free-running clock; both ends share it.
    always #10 aclk = ~aclk;

    clkrst_if lnk();
    dma_global_clock_reset_status #(.SOFT_RESET_EN(1'b1)) i_dma_global_clock_reset_status (
        .aclk(aclk), .aresetn(aresetn), .ref_is_250(ref_is_250),
        .core_link_up(core_link_up), .core_msi_enable(core_msi_enable),
        .core_msix_enable(core_msix_enable), .core_msi_vecs(core_msi_vecs),
        .sys_clk_tick(sys_clk_tick), .engine_resetn(engine_resetn), .lnk(lnk));
    user_fabric_end #(.HOLD_CYCLES(HOLD)) i_user_fabric_end (
        .aclk(aclk), .aresetn(aresetn), .perst_n(perst_n), .traffic_idle(traffic_idle),
        .fabric_aresetn(fabric_aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .lnk(lnk));
    clkrst_sva #(.HOLD_CYCLES(HOLD)) i_clkrst_sva (
        .aclk(aclk), .aresetn(aresetn), .sys_rst_n(lnk.sys_rst_n),
        .soft_resetn(lnk.soft_resetn), .fabric_clk(lnk.fabric_clk),
        .fabric_resetn(lnk.fabric_resetn), .link_up(lnk.link_up),
        .msi_enable(lnk.msi_enable), .msix_enable(lnk.msix_enable),
        .msi_vector_width(lnk.msi_vector_width));

    // ============================================================
    // Tasks
    task automatic complete_run();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A wait that ran out of its bound ends the run as a failure.
    task automatic give_up(input int n);
        if (n >= 200) begin
            n_mismatch++;
            complete_run();
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge aclk);
    endtask

    // Address and data go out together; each drops as soon as it is taken.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        int n;
        done = 1'b0;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done && n < 200) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
        give_up(n);
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        int n;
        done = 1'b0;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done && n < 200) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        give_up(n);
        @(posedge aclk);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        int n;
        logic [31:0] d;
        logic [1:0] r;
        cycles(6);
        aresetn <= 1'b1;
        cycles(4);
        // Edge connector still in reset: fabric held and status clear.
        axi_rd(`REG_STATUS, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, `RESP_OKAY});
        chk({31'h0, sys_clk_tick}, 32'h1);
        @(posedge aclk);
        chk({31'h0, sys_clk_tick}, 32'h1);
        perst_n <= 1'b1;
        n = 0;
        while (lnk.fabric_resetn !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        give_up(n);
        chk({31'h0, n > 32}, 32'h1);
        @(posedge aclk);
        chk({31'h0, fabric_aresetn}, 32'h1);
        // Walk all eight link, MSI and MSI-X enable patterns; the last leaves the link up for the soft reset.
        for (int i = 0; i < 8; i++) begin
            core_link_up <= i[0];
            core_msi_enable <= i[1];
            core_msix_enable <= i[2];
            core_msi_vecs <= 3'(i) ^ 3'h5;
            cycles(5);
            axi_rd(`REG_STATUS, d, r);
            chk(d, {24'h0, 2'b01, 3'(i) ^ 3'h5, i[2:0]});
        end
        axi_wr(4'h8, 32'hFF, r);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        axi_rd(4'h8, d, r);
        chk(d, {30'h0, r} ^ {30'h0, `RESP_SLVERR});
        // Soft reset waits for quiet traffic before it starts.
        axi_wr(`REG_CTRL, 32'h1, r);
        cycles(8);
        axi_rd(`REG_CTRL, d, r);
        chk(d, 32'h1);
        chk({31'h0, lnk.soft_resetn}, 32'h1);
        traffic_idle <= 1'b1;
        n = 0;
        while (lnk.soft_resetn !== 1'b0 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        give_up(n);
        cycles(3);
        chk({29'h0, engine_resetn, lnk.fabric_resetn, lnk.link_up}, 32'h1);
        n = 0;
        while (lnk.soft_resetn !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        give_up(n);
        chk(n, HOLD - 3);
        // A request while busy is dropped without error.
        axi_wr(`REG_CTRL, 32'h1, r);
        axi_rd(`REG_CTRL, d, r);
        chk(d, 32'h1);
        n = 0;
        while (lnk.fabric_resetn !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        give_up(n);
        cycles(3);
        axi_rd(`REG_STATUS, d, r);
        chk(d, 32'hD7);
        axi_rd(`REG_CTRL, d, r);
        chk(d, 32'h0);
        axi_wr(`REG_STATUS, 32'h80, r);
        axi_rd(`REG_STATUS, d, r);
        chk(d, 32'h57);
        // Second reset with a 250 MHz reference: the tick runs at half rate.
        ref_is_250 <= 1'b1;
        aresetn <= 1'b0;
        cycles(6);
        aresetn <= 1'b1;
        cycles(6);
        d[0] = sys_clk_tick;
        @(posedge aclk);
        chk({31'h0, sys_clk_tick}, {31'h0, ~d[0]});
        complete_run();
    end
endmodule
